// file: hccc_consts.vh
// constants of the host channel coupler control block
// assumes a 12-bit channel code, octal function numbering
`ifndef HCCC_CONSTS_VH
`define HCCC_CONSTS_VH

// channel code fields
`define HCCC_CODE_W        12
`define HCCC_UNIT_HI       11
`define HCCC_UNIT_LO       9
`define HCCC_OP_HI         11
`define HCCC_OP_LO         6
`define HCCC_PAT_W         10

// function codes, full 12 bits; octal 0001..0040 written in hex
`define HCCC_FN_PAIRED     12'h001
`define HCCC_FN_SINGLE     12'h002
`define HCCC_FN_RW_EN      12'h004
`define HCCC_FN_RW_OFF     12'h008
`define HCCC_FN_CLR_EN     12'h010
`define HCCC_FN_CLR_ST     12'h020

// function groups selected by the top two octal digits 01, 10, 11
`define HCCC_OP_MASK       6'h01
`define HCCC_OP_SET        6'h08
`define HCCC_OP_CLR        6'h09

// status register layout
`define HCCC_ST_W          12
`define HCCC_ST_WR_RDY     10
`define HCCC_ST_RD_RDY     11

// reset values
`define HCCC_ST_RST        12'h000
`define HCCC_MASK_RST      10'h000
`define HCCC_MODE_RST      1'b0

// mapping modes
`define HCCC_MODE_PAIRED   1'b0
`define HCCC_MODE_SINGLE   1'b1

// parity sense: 1 means total of data and parity is odd
`define HCCC_PAR_ODD       1'b1

// pin synchroniser depth
`define HCCC_SYNC_STAGES   3

`endif

// file: hccc_sync.v
// three-stage synchroniser with agreement filter for channel pins
// assumes inputs asynchronous to clock_in
`timescale 1ns/1ps
`default_nettype none

module hccc_sync #(
   parameter W = 1
) (
   input  wire         clock_in,
   input  wire         arst_n_in,
   input  wire [W-1:0] d_in,
   output wire [W-1:0] q_out
);

   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   reg [W-1:0] s3_q;
   genvar      i;

   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         s1_q <= {W{1'b0}};
         s2_q <= {W{1'b0}};
         s3_q <= {W{1'b0}};
      end else begin
         // first stage feeds only the second
         s1_q <= d_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // a bit changes only once stages two and three agree
   generate
      for (i = 0; i < W; i = i + 1) begin : g_filt
         reg filt_q;
         always @(posedge clock_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
               filt_q <= 1'b0;
            end else if (s2_q[i] == s3_q[i]) begin
               filt_q <= s3_q[i];
            end
         end
         assign q_out[i] = filt_q;
      end
   endgenerate

endmodule // hccc_sync

`default_nettype wire

// file: hccc_coupler.v
// host channel coupler control: connect, functions, status, interrupt
// assumes channel pins asynchronous; minicomputer side on clock_in
`timescale 1ns/1ps
`default_nettype none
`include "hccc_consts.vh"

module hccc_coupler #(
   parameter       UNIT_W  = 3,
   parameter [0:0] PAR_ODD = `HCCC_PAR_ODD
) (
   input  wire        clock_in,
   input  wire        arst_n_in,
   // channel side pins
   input  wire        chan_connect_in,
   input  wire        chan_function_in,
   input  wire [11:0] chan_data_in,
   input  wire        chan_parity_in,
   input  wire [2:0]  unit_select_in,
   input  wire        unit_present_in,
   output wire        chan_reply_out,
   output wire        chan_reject_out,
   output wire        chan_irq_out,
   // minicomputer status and control channel
   input  wire        ctl_set_in,
   input  wire        ctl_clr_in,
   input  wire [11:0] ctl_pattern_in,
   output wire [11:0] ctl_status_out,
   output wire        ctl_connected_out,
   output wire        ctl_single_byte_mapping_out,
   // minicomputer data channel, outbound
   input  wire        dat_wr_in,
   input  wire [15:0] dat_word_in,
   output wire [11:0] dat_byte_first_out,
   output wire [11:0] dat_byte_second_out,
   output wire        dat_two_bytes_out,
   // minicomputer data channel, inbound
   input  wire        dat_byte_vld_in,
   input  wire [11:0] dat_byte_in,
   output wire [15:0] dat_word_out,
   output wire        dat_word_vld_out
);

   localparam SW = 2 + 1 + 12 + UNIT_W + 1;

   localparam [1:0] ST_IDLE  = 2'd0;
   localparam [1:0] ST_CONN  = 2'd1;
   localparam [1:0] ST_FUNC  = 2'd2;
   localparam [1:0] ST_HOLD  = 2'd3;

   // function kinds
   localparam [3:0] FK_NONE   = 4'd0;
   localparam [3:0] FK_PAIR   = 4'd1;
   localparam [3:0] FK_SINGLE = 4'd2;
   localparam [3:0] FK_RW_EN  = 4'd3;
   localparam [3:0] FK_RW_OFF = 4'd4;
   localparam [3:0] FK_CLR_EN = 4'd5;
   localparam [3:0] FK_CLR_ST = 4'd6;
   localparam [3:0] FK_MASK   = 4'd7;
   localparam [3:0] FK_SET    = 4'd8;
   localparam [3:0] FK_CLR    = 4'd9;

   function [3:0] fn_kind;
      input [11:0] code;
      begin
         case (code)
            `HCCC_FN_PAIRED: fn_kind = FK_PAIR;
            `HCCC_FN_SINGLE: fn_kind = FK_SINGLE;
            `HCCC_FN_RW_EN:  fn_kind = FK_RW_EN;
            `HCCC_FN_RW_OFF: fn_kind = FK_RW_OFF;
            `HCCC_FN_CLR_EN: fn_kind = FK_CLR_EN;
            `HCCC_FN_CLR_ST: fn_kind = FK_CLR_ST;
            default:
               case (code[`HCCC_OP_HI:`HCCC_OP_LO])
                  `HCCC_OP_MASK: fn_kind = FK_MASK;
                  `HCCC_OP_SET:  fn_kind = FK_SET;
                  `HCCC_OP_CLR:  fn_kind = FK_CLR;
                  default:       fn_kind = FK_NONE;
               endcase
         endcase
      end
   endfunction

   // synchronised pins
   wire [SW-1:0]     pins_s;
   wire              conn_s, func_s, par_s, present_s;
   wire [11:0]       data_s;
   wire [UNIT_W-1:0] unit_s;
   hccc_sync #(
      .W (SW)
   ) u_sync (
      .clock_in  (clock_in),
      .arst_n_in (arst_n_in),
      .d_in      ({chan_connect_in, chan_function_in, chan_parity_in,
                   chan_data_in, unit_select_in, unit_present_in}),
      .q_out     (pins_s)
   );
   assign {conn_s, func_s, par_s, data_s, unit_s, present_s} = pins_s;

   reg         conn_prev_q, func_prev_q;
   reg [1:0]   state_q, state_d;
   reg         reply_q, reply_d;
   reg         reject_q, reject_d;
   reg         connected_q, connected_d;
   reg         exec_d;
   reg         mode_q;
   reg         rw_en_q, rw_pend_q;
   reg         clr_en_q, clr_pend_q;
   reg [9:0]   mask_q;
   reg [11:0]  status_q, status_d;
   reg         irq_q;
   reg [11:0]  obyte0_q, obyte1_q;
   reg         otwo_q;
   reg [7:0]   ihalf_q;
   reg         iphase_q;
   reg [15:0]  iword_q;
   reg         ivld_q;

   wire conn_rise = conn_s & ~conn_prev_q;
   wire func_rise = func_s & ~func_prev_q;
   // parity sense chosen at build time
   wire par_ok    = ((^data_s) ^ par_s) == PAR_ODD;
   wire unit_hit  = data_s[`HCCC_UNIT_HI:`HCCC_UNIT_LO] == unit_s;
   wire [3:0] fk  = fn_kind(data_s);
   wire fn_ok     = (fk != FK_NONE) & par_ok;

   // answer sequencer: reply and reject stand until the strobe drops
   always @* begin
      state_d     = state_q;
      reply_d     = reply_q;
      reject_d    = reject_q;
      connected_d = connected_q;
      exec_d      = 1'b0;
      case (state_q)
         ST_IDLE: begin
            if (conn_rise) begin
               if (unit_hit & par_ok & present_s) begin
                  reply_d     = 1'b1;
                  connected_d = 1'b1;
                  state_d     = ST_CONN;
               end else if (!par_ok | (unit_hit & ~present_s)) begin
                  reject_d    = 1'b1;
                  connected_d = 1'b0;
                  state_d     = ST_CONN;
               end else begin
                  // another unit was addressed
                  connected_d = 1'b0;
                  state_d     = ST_HOLD;
               end
            end else if (func_rise & connected_q) begin
               if (fn_ok) begin
                  reply_d = 1'b1;
                  exec_d  = 1'b1;
                  state_d = ST_FUNC;
               end else begin
                  // silence lets the channel reject internally
                  state_d = ST_HOLD;
               end
            end
         end
         ST_CONN: begin
            if (!conn_s) begin
               reply_d  = 1'b0;
               reject_d = 1'b0;
               state_d  = ST_IDLE;
            end
         end
         ST_FUNC: begin
            if (!func_s) begin
               reply_d = 1'b0;
               state_d = ST_IDLE;
            end
         end
         ST_HOLD: begin
            if (!conn_s & !func_s) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d  = ST_IDLE;
            reply_d  = 1'b0;
            reject_d = 1'b0;
         end
      endcase
   end

   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_q     <= ST_IDLE;
         reply_q     <= 1'b0;
         reject_q    <= 1'b0;
         connected_q <= 1'b0;
         conn_prev_q <= 1'b0;
         func_prev_q <= 1'b0;
      end else begin
         conn_prev_q <= conn_s;
         func_prev_q <= func_s;
         state_q     <= state_d;
         reply_q     <= reply_d;
         reject_q    <= reject_d;
         connected_q <= connected_d;
      end
   end

   wire do_clr_st = exec_d & (fk == FK_CLR_ST);
   wire [9:0] pat = data_s[`HCCC_PAT_W-1:0];
   // status: minicomputer and channel may both set and clear;
   // any set wins over a clear landing in the same cycle
   always @* begin
      status_d = status_q;
      if (do_clr_st)
         status_d = `HCCC_ST_RST;
      if (exec_d & (fk == FK_CLR))
         status_d[9:0] = status_d[9:0] & ~pat;
      if (ctl_clr_in)
         status_d = status_d & ~ctl_pattern_in;
      if (exec_d & (fk == FK_SET))
         status_d[9:0] = status_d[9:0] | pat;
      if (ctl_set_in)
         status_d = status_d | ctl_pattern_in;
   end

   wire rw_event  = (status_d[`HCCC_ST_WR_RDY] &
                     ~status_q[`HCCC_ST_WR_RDY]) |
                    (status_d[`HCCC_ST_RD_RDY] &
                     ~status_q[`HCCC_ST_RD_RDY]);
   wire clr_event = ctl_clr_in & (status_q != `HCCC_ST_RST) &
                    (status_d == `HCCC_ST_RST);
   wire mask_hit  = |(mask_q & status_q[9:0]);

   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         status_q   <= `HCCC_ST_RST;
         mode_q     <= `HCCC_MODE_RST;
         rw_en_q    <= 1'b0;
         rw_pend_q  <= 1'b0;
         clr_en_q   <= 1'b0;
         clr_pend_q <= 1'b0;
         mask_q     <= `HCCC_MASK_RST;
         irq_q      <= 1'b0;
      end else begin
         status_q <= status_d;
         // interrupt does not look at the connection state
         irq_q    <= rw_pend_q | clr_pend_q | mask_hit;
         if (exec_d & (fk == FK_PAIR)) begin
            mode_q <= `HCCC_MODE_PAIRED;
         end
         if (exec_d & (fk == FK_SINGLE)) begin
            mode_q <= `HCCC_MODE_SINGLE;
         end
         if (exec_d & (fk == FK_MASK)) begin
            mask_q <= pat;
         end
         // the cancelling function also drops the enable, so it wins
         if (exec_d & (fk == FK_RW_OFF)) begin
            rw_en_q   <= 1'b0;
            rw_pend_q <= 1'b0;
         end else begin
            if (exec_d & (fk == FK_RW_EN)) begin
               rw_en_q <= 1'b1;
            end
            if (rw_en_q & rw_event) begin
               rw_pend_q <= 1'b1;
            end
         end
         if (do_clr_st) begin
            clr_en_q   <= 1'b0;
            clr_pend_q <= 1'b0;
         end else begin
            if (exec_d & (fk == FK_CLR_EN)) begin
               clr_en_q <= 1'b1;
            end
            if (clr_en_q & clr_event) begin
               clr_pend_q <= 1'b1;
            end
         end
      end
   end

   // outbound mapping, word to channel bytes
   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         obyte0_q <= 12'h000;
         obyte1_q <= 12'h000;
         otwo_q   <= 1'b0;
      end else if (dat_wr_in) begin
         if (mode_q == `HCCC_MODE_SINGLE) begin
            obyte0_q <= {dat_word_in[13:8], dat_word_in[5:0]};
            obyte1_q <= 12'h000;
            otwo_q   <= 1'b0;
         end else begin
            obyte0_q <= {4'h0, dat_word_in[15:8]};
            obyte1_q <= {4'h0, dat_word_in[7:0]};
            otwo_q   <= 1'b1;
         end
      end
   end

   // inbound mapping, channel bytes to word; a mode change
   // restarts pairing so a stray half byte is dropped
   always @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ihalf_q  <= 8'h00;
         iphase_q <= 1'b0;
         iword_q  <= 16'h0000;
         ivld_q   <= 1'b0;
      end else begin
         ivld_q <= 1'b0;
         if (exec_d & ((fk == FK_PAIR) | (fk == FK_SINGLE))) begin
            iphase_q <= 1'b0;
         end else if (dat_byte_vld_in) begin
            if (mode_q == `HCCC_MODE_SINGLE) begin
               iword_q <= {2'b00, dat_byte_in[11:6],
                           2'b00, dat_byte_in[5:0]};
               ivld_q  <= 1'b1;
            end else if (!iphase_q) begin
               ihalf_q  <= dat_byte_in[7:0];
               iphase_q <= 1'b1;
            end else begin
               iword_q  <= {ihalf_q, dat_byte_in[7:0]};
               ivld_q   <= 1'b1;
               iphase_q <= 1'b0;
            end
         end
      end
   end

   assign chan_reply_out              = reply_q;
   assign chan_reject_out             = reject_q;
   assign chan_irq_out                = irq_q;
   // status and control channel
   assign ctl_status_out              = status_q;
   assign ctl_connected_out           = connected_q;
   assign ctl_single_byte_mapping_out = mode_q;
   // data channel
   assign dat_byte_first_out          = obyte0_q;
   assign dat_byte_second_out         = obyte1_q;
   assign dat_two_bytes_out           = otwo_q;
   assign dat_word_out                = iword_q;
   assign dat_word_vld_out            = ivld_q;

endmodule // hccc_coupler

`default_nettype wire

// file: hccc_chk.sv
// checker for hccc_coupler: watches the top ports only
// assumes one clock domain and the active-low async reset
`timescale 1ns/1ps
`default_nettype none
`include "hccc_consts.vh"
module hccc_chk (
   input wire logic        clock_in,
   input wire logic        arst_n_in,
   input wire logic        chan_connect_in,
   input wire logic        chan_function_in,
   input wire logic [11:0] chan_data_in,
   input wire logic        chan_reply_out,
   input wire logic        chan_reject_out,
   input wire logic        ctl_set_in,
   input wire logic [11:0] ctl_status_out,
   input wire logic        ctl_connected_out,
   input wire logic        ctl_single_byte_mapping_out
);
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!arst_n_in);

   // the code pins are held until the strobe drops, so they are valid here
   conn_reply_a:
      assert property ($rose(chan_reply_out) && chan_connect_in |->
         ctl_connected_out) else $error("reply left unit unconnected");
   rej_unconn_a:
      assert property ($rose(chan_reject_out) |-> !ctl_connected_out)
         else $error("reject with unit connected");
   fn_valid_a:
      assert property ($rose(chan_reply_out) && chan_function_in |->
         chan_data_in inside {`HCCC_FN_PAIRED, `HCCC_FN_SINGLE,
         `HCCC_FN_RW_EN, `HCCC_FN_RW_OFF, `HCCC_FN_CLR_EN, `HCCC_FN_CLR_ST}
         || chan_data_in[11:6] inside {`HCCC_OP_MASK, `HCCC_OP_SET,
         `HCCC_OP_CLR}) else $error("reply to invalid code");
   mode_one_a:
      assert property ($rose(chan_reply_out) && chan_function_in &&
         chan_data_in == `HCCC_FN_SINGLE |-> ctl_single_byte_mapping_out)
         else $error("single mapping not selected");
   mode_two_a:
      assert property ($rose(chan_reply_out) && chan_function_in &&
         chan_data_in == `HCCC_FN_PAIRED |-> !ctl_single_byte_mapping_out)
         else $error("paired mapping not selected");
   grp_set_a:
      assert property ($rose(chan_reply_out) && chan_function_in &&
         chan_data_in[11:6] == `HCCC_OP_SET |->
         (ctl_status_out[9:0] & chan_data_in[9:0]) == chan_data_in[9:0])
         else $error("status bits not set");
   grp_clr_a:
      assert property ($rose(chan_reply_out) && chan_function_in &&
         chan_data_in[11:6] == `HCCC_OP_CLR && !$past(ctl_set_in) |->
         (ctl_status_out[9:0] & chan_data_in[9:0]) == 10'h000)
         else $error("status bits not cleared");
   st_clr_a:
      assert property ($rose(chan_reply_out) && chan_function_in &&
         chan_data_in == `HCCC_FN_CLR_ST && !$past(ctl_set_in) |->
         ctl_status_out == 12'h000)
         else $error("status not cleared");
endmodule // hccc_chk
`default_nettype wire

// file: hccc_chan_model.sv
// channel converter model: sends connect and function codes
// assumes the coupler answers with reply or reject within 12 clocks
`timescale 1ns/1ps
`default_nettype none
module hccc_chan_model #(
   parameter [0:0] PAR_ODD = 1'b1
) (
   input  wire logic        clock_in,
   input  wire logic        reply_in,
   input  wire logic        reject_in,
   output var  logic        connect_out,
   output var  logic        function_out,
   output var  logic [11:0] data_out,
   output var  logic        parity_out
);
   initial begin
      connect_out = 1'h0;
      function_out = 1'h0;
      data_out = 12'h000;
      parity_out = 1'h0;
   end
   // ans = {reject, reply}; zero means the channel rejects internally
   task automatic op(input logic fn, input logic [11:0] code,
                     input logic bad, output logic [1:0] ans);
      int n;
      @(posedge clock_in);
      #1;
      data_out = code;
      parity_out = ^code ^ PAR_ODD ^ bad;
      // code settles ahead of the strobe, past the pin filter
      repeat (4) @(posedge clock_in);
      #1;
      connect_out = !fn;
      function_out = fn;
      ans = 2'h0;
      for (n = 0; n < 12 && ans == 2'h0; n++) begin
         @(posedge clock_in);
         ans = {reject_in, reply_in};
      end
      #1;
      connect_out = 1'h0;
      function_out = 1'h0;
      repeat (8) @(posedge clock_in);
      #1;
      // released lines must not keep showing the old code
      data_out = ~code;
      parity_out = ~parity_out;
   endtask
endmodule // hccc_chan_model
`default_nettype wire

// file: host_channel_coupler_control_test.sv
// bench for hccc_coupler: link, status, interrupt and word mapping
// assumes hccc_chan_model on the channel and hccc_chk bound below
`timescale 1ns/1ps
`default_nettype none
`include "hccc_consts.vh"
module host_channel_coupler_control_test;
   logic        clock_in = 1'h0, arst_n_in = 1'h0, present = 1'h0;
   logic        set = 1'h0, clr = 1'h0, wr = 1'h0, bvld = 1'h0, vld;
   logic        con, fnc, par, reply, reject, irq, conn, single, two, wvld;
   logic [11:0] dat, status, bf, bs;
   logic [15:0] val = 16'h0000, wout;
   int          failures, num_checks, cycles;

   hccc_coupler dut (.clock_in(clock_in), .arst_n_in(arst_n_in),
      .chan_connect_in(con), .chan_function_in(fnc), .chan_data_in(dat),
      .chan_parity_in(par), .unit_select_in(3'h5), .unit_present_in(present),
      .chan_reply_out(reply), .chan_reject_out(reject), .chan_irq_out(irq),
      .ctl_set_in(set), .ctl_clr_in(clr), .ctl_pattern_in(val[11:0]),
      .ctl_status_out(status), .ctl_connected_out(conn),
      .ctl_single_byte_mapping_out(single), .dat_wr_in(wr),
      .dat_word_in(val), .dat_byte_first_out(bf), .dat_byte_second_out(bs),
      .dat_two_bytes_out(two), .dat_byte_vld_in(bvld),
      .dat_byte_in(val[11:0]), .dat_word_out(wout), .dat_word_vld_out(wvld));
   hccc_chan_model u_chan (.clock_in(clock_in), .reply_in(reply),
      .reject_in(reject), .connect_out(con), .function_out(fnc),
      .data_out(dat), .parity_out(par));

   always #4 clock_in = ~clock_in;
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 4000) begin
         failures++;
         $display("ERROR %0t: timeout", $time);
         test_done();
      end
   end

   task cmp(input logic [15:0] g, input logic [15:0] e);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("ERROR %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task cmp1(input logic g, input logic e);
      cmp({15'h0000, g}, {15'h0000, e});
   endtask
   task op(input logic f, input logic [11:0] c, input logic b,
           input logic [1:0] e);
      logic [1:0] a;
      u_chan.op(f, c, b, a);
      cmp({14'h0000, a}, {14'h0000, e});
   endtask
   // k = {set, clear, word write, byte valid}; irq lags status, so settle
   task poke(input logic [3:0] k, input logic [15:0] v);
      @(posedge clock_in);
      #1;
      val = v;
      {set, clr, wr, bvld} = k;
      @(posedge clock_in);
      #1;
      {set, clr, wr, bvld} = 4'h0;
      vld = wvld;
      repeat (2) @(posedge clock_in);
      #1;
   endtask
   task test_done;
      $display("checks %0d, failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task t_link;
      op(0, 12'hA12, 0, 2'h2);
      present = 1'h1;
      op(0, 12'hA12, 1, 2'h2);
      cmp1(conn, 1'h0);
      op(0, 12'hA12, 0, 2'h1);
      cmp1(conn, 1'h1);
      op(1, 12'h003, 0, 2'h0);
      op(1, `HCCC_FN_SINGLE, 1, 2'h0);
      cmp1(single, 1'h0);
      op(1, `HCCC_FN_SINGLE, 0, 2'h1);
      cmp1(single, 1'h1);
      op(1, `HCCC_FN_PAIRED, 0, 2'h1);
      cmp1(single, 1'h0);
      $display("t_link done");
   endtask
   task t_status;
      poke(4'h8, 16'h0C00);
      op(1, 12'h215, 0, 2'h1);
      cmp({4'h0, status}, 16'h0E15);
      op(1, 12'h241, 0, 2'h1);
      cmp({4'h0, status}, 16'h0C14);
      poke(4'h4, 16'h0004);
      cmp({4'h0, status}, 16'h0C10);
      op(1, `HCCC_FN_CLR_ST, 0, 2'h1);
      cmp({4'h0, status}, 16'h0000);
      $display("t_status done");
   endtask
   task t_irq;
      op(1, 12'h041, 0, 2'h1);
      poke(4'h8, 16'h0001);
      cmp1(irq, 1'h1);
      poke(4'h4, 16'h0001);
      cmp1(irq, 1'h0);
      poke(4'h8, 16'h0002);
      cmp1(irq, 1'h0);
      op(1, `HCCC_FN_RW_EN, 0, 2'h1);
      op(0, 12'h412, 0, 2'h0);
      cmp1(conn, 1'h0);
      poke(4'h8, 16'h0400);
      cmp1(irq, 1'h1);
      op(0, 12'hA12, 0, 2'h1);
      op(1, `HCCC_FN_RW_OFF, 0, 2'h1);
      cmp1(irq, 1'h0);
      poke(4'h8, 16'h0800);
      cmp1(irq, 1'h0);
      op(1, `HCCC_FN_CLR_EN, 0, 2'h1);
      poke(4'h4, 16'h0FFF);
      cmp1(irq, 1'h1);
      op(1, `HCCC_FN_CLR_ST, 0, 2'h1);
      cmp1(irq, 1'h0);
      $display("t_irq done");
   endtask
   task t_data;
      poke(4'h2, 16'hABCD);
      cmp({4'h0, bf}, 16'h00AB);
      cmp({4'h0, bs}, 16'h00CD);
      cmp1(two, 1'h1);
      poke(4'h1, 16'h00AB);
      cmp1(vld, 1'h0);
      poke(4'h1, 16'h00CD);
      cmp1(vld, 1'h1);
      cmp(wout, 16'hABCD);
      op(1, `HCCC_FN_SINGLE, 0, 2'h1);
      poke(4'h2, 16'h9A5C);
      cmp({4'h0, bf}, 16'h069C);
      cmp1(two, 1'h0);
      poke(4'h1, 16'h0FFF);
      cmp1(vld, 1'h1);
      cmp(wout, 16'h3F3F);
      $display("t_data done");
   endtask

   initial begin
      repeat (12) @(posedge clock_in);
      #1;
      arst_n_in = 1'h1;
      t_link();
      t_status();
      t_irq();
      t_data();
      test_done();
   end
endmodule // host_channel_coupler_control_test

bind hccc_coupler hccc_chk u_chk (.clock_in, .arst_n_in, .chan_connect_in,
   .chan_function_in, .chan_data_in, .chan_reply_out, .chan_reject_out,
   .ctl_set_in, .ctl_status_out, .ctl_connected_out,
   .ctl_single_byte_mapping_out);
`default_nettype wire
